// ===== strap_pkg.sv
package strap_pkg;

  localparam int          CODE_W       = 16;
  localparam int          ADDR_W       = 7;
  localparam int          DEB_W        = 8;
  localparam int          STRAP_N      = 17;

  // Thermometer codes of the strap resistor steps
  localparam logic [15:0] CODE_GND     = 16'h0000;
  localparam logic [15:0] CODE_STEP1   = 16'h0001;
  localparam logic [15:0] CODE_STEP2   = 16'h0003;
  localparam logic [15:0] CODE_STEP3   = 16'h0007;
  localparam logic [15:0] CODE_STEP4   = 16'h000F;
  localparam logic [15:0] CODE_STEP5   = 16'h001F;
  localparam logic [15:0] CODE_STEP6   = 16'h003F;
  localparam logic [15:0] CODE_STEP7   = 16'h007F;
  localparam logic [15:0] CODE_STEP8   = 16'h00FF;
  localparam logic [15:0] CODE_STEP9   = 16'h01FF;
  localparam logic [15:0] CODE_STEP10  = 16'h03FF;
  localparam logic [15:0] CODE_STEP11  = 16'h07FF;
  localparam logic [15:0] CODE_STEP12  = 16'h0FFF;
  localparam logic [15:0] CODE_STEP13  = 16'h1FFF;
  localparam logic [15:0] CODE_STEP14  = 16'h3FFF;
  localparam logic [15:0] CODE_STEP15  = 16'h7FFF;
  localparam logic [15:0] CODE_TOP     = 16'hFFFF;

  localparam logic [6:0]  ADDR_STEP0   = 7'h5F;
  localparam logic [6:0]  ADDR_STEP1   = 7'h5E;
  localparam logic [6:0]  ADDR_STEP2   = 7'h5D;
  localparam logic [6:0]  ADDR_STEP3   = 7'h5C;
  localparam logic [6:0]  ADDR_STEP4   = 7'h6B;
  localparam logic [6:0]  ADDR_STEP5   = 7'h6A;
  localparam logic [6:0]  ADDR_STEP6   = 7'h69;
  localparam logic [6:0]  ADDR_STEP7   = 7'h68;
  localparam logic [6:0]  ADDR_STEP8   = 7'h77;
  localparam logic [6:0]  ADDR_STEP9   = 7'h76;
  localparam logic [6:0]  ADDR_STEP10  = 7'h75;
  localparam logic [6:0]  ADDR_STEP11  = 7'h74;
  localparam logic [6:0]  ADDR_STEP12  = 7'h71;
  localparam logic [6:0]  ADDR_STEP13  = 7'h73;
  localparam logic [6:0]  ADDR_STEP14  = 7'h70;
  localparam logic [6:0]  ADDR_STEP15  = 7'h72;
  localparam logic [6:0]  ADDR_TOP     = 7'h48;

  // Reset defaults before the straps are sampled
  localparam logic [6:0]  ADDR_RESET   = 7'h5F;
  localparam logic [15:0] CODE_RESET   = 16'hFFFF;

  // One less than the cycles the strap pins must be steady before they are taken
  localparam int          SETTLE_CYC   = 16;
  localparam logic [4:0]  SETTLE_CNT   = 5'(SETTLE_CYC);

  typedef enum logic [3:0] {
    OPMODE_RESET     = 4'h1,
    OPMODE_STANDDOWN = 4'h2,
    OPMODE_STANDUP   = 4'h4,
    OPMODE_COMPANION = 4'h8
  } opmode_e;

  typedef struct packed {
    opmode_e            mode;
    logic [3:0]         sub_mode;
    logic [ADDR_W-1:0]  target_addr;
    logic [CODE_W-1:0]  mode_code;
    logic [CODE_W-1:0]  addr_code;
  } strap_cfg_s;

  typedef struct packed {
    logic cc1_back_drive_err;
    logic cc2_back_drive_err;
  } power_flags_s;

endpackage : strap_pkg

// ===== back_drive_lane.sv
`timescale 1ns/10ps
module back_drive_lane
  import strap_pkg::*;
(
  input  wire logic             MCLK_I,
  input  wire logic             RST_B_I,
  input  wire logic             over_i,
  input  wire logic             enable_i,
  input  wire logic [DEB_W-1:0] debounce_i,
  input  wire logic             clear_i,
  output logic                  flag_o,
  output logic                  fet_off_o
);
  logic [2:0]       sync_q, sync_d;
  logic             level_q, level_d;
  logic [DEB_W-1:0] cnt_q, cnt_d;
  logic             flag_q, flag_d;
  logic             off_q, off_d;

  always_comb begin
    sync_d  = {sync_q[1:0], over_i};
    level_d = (sync_q[2] == sync_q[1]) ? sync_q[2] : level_q;
    // Flag set wins over a clear in the same cycle
    flag_d  = level_q | (flag_q & ~clear_i);
    cnt_d   = level_q ? cnt_q : '0;
    off_d   = off_q;
    if (level_q && cnt_q != debounce_i) begin
      cnt_d = cnt_q + 1'b1;
    end
    if (!level_q) begin
      off_d = 1'b0;
    end else if (enable_i && cnt_q == debounce_i) begin
      off_d = 1'b1;
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      sync_q  <= '0;
      level_q <= 1'b0;
      cnt_q   <= '0;
      flag_q  <= 1'b0;
      off_q   <= 1'b0;
    end else begin
      sync_q  <= sync_d;
      level_q <= level_d;
      cnt_q   <= cnt_d;
      flag_q  <= flag_d;
      off_q   <= off_d;
    end
  end

  assign flag_o    = flag_q;
  assign fet_off_o = off_q;
endmodule : back_drive_lane

// ===== strap_decode_backdrive.sv
// Functional notes
// - Sample both straps after every system reset
// - Code 0000h downstream, 0001h upstream standalone
// - Strap codes are thermometer codes
// - Other mode codes select companion sub-modes
// - Address steps 0-3 give 1011_1xx
// - Address steps 4-7 give 1101_0xx
// - Address steps 8-11 give 1110_1xx
// - Address steps 12-15 non-monotonic 1110_0xx
// - Top code FFFFh gives address 1001_000
// - Back-drive watched always on both pins
// - Back-drive sets per-pin error flag
// - Enabled: FET off after debounce period
// - Standalone entered from straps alone
// - Capability pins pick downstream current level
// - Standalone self-configures after each reset
`timescale 1ns/10ps
module strap_decode_backdrive
  import strap_pkg::*;
(
  input  wire logic                 MCLK_I,
  input  wire logic                 RST_B_I,
  input  wire logic                 SOFT_RESET_I,
  input  wire logic [STRAP_N-2:0]   MODE_STRAP_PIN_I,
  input  wire logic [STRAP_N-2:0]   ADDRESS_STRAP_PIN_I,
  input  wire logic                 POWER_CAPABILITY_PIN_0_I,
  input  wire logic                 POWER_CAPABILITY_PIN_1_I,
  input  wire logic                 STANDALONE_DISABLE_I,
  input  wire logic                 CC1_OVER_SUPPLY_I,
  input  wire logic                 CC2_OVER_SUPPLY_I,
  input  wire logic                 BACK_DRIVE_ENABLE_I,
  input  wire logic [DEB_W-1:0]     VCONN_FAULT_DEBOUNCE_I,
  input  wire logic [1:0]           POWER_EVENT_CLEAR_I,
  output strap_pkg::strap_cfg_s     CFG_O,
  output logic                      CFG_VALID_O,
  output logic                      STANDALONE_DOWN_O,
  output logic                      STANDALONE_UP_O,
  output logic [1:0]                CURRENT_LEVEL_O,
  output strap_pkg::power_flags_s   POWER_EVENT_FLAGS_O,
  output logic                      CC1_VCONN_OFF_O,
  output logic                      CC2_VCONN_OFF_O
);
  import strap_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Strap pin synchronisers, three stages each

  logic [CODE_W-1:0] ms1_q, ms2_q, ms3_q, as1_q, as2_q, as3_q;
  logic [CODE_W-1:0] ms_d, as_d;

  always_comb begin
    ms_d = MODE_STRAP_PIN_I;
    as_d = ADDRESS_STRAP_PIN_I;
  end

  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ms1_q <= '0;
      ms2_q <= '0;
      ms3_q <= '0;
      as1_q <= '0;
      as2_q <= '0;
      as3_q <= '0;
    end else begin
      ms1_q <= ms_d;
      ms2_q <= ms1_q;
      ms3_q <= ms2_q;
      as1_q <= as_d;
      as2_q <= as1_q;
      as3_q <= as2_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Thermometer normalisation: pin i set means level above step i

  function automatic logic [CODE_W-1:0] to_code(input logic [CODE_W-1:0] raw);
    logic [CODE_W-1:0] c;
    c = raw;
    for (int i = CODE_W - 2; i >= 0; i--) begin
      c[i] = c[i] | c[i+1];
    end
    // Top bit alone marks a level above the highest step
    return c;
  endfunction : to_code

  function automatic logic [ADDR_W-1:0] addr_of(input logic [CODE_W-1:0] c);
    logic [ADDR_W-1:0] a;
    a = ADDR_TOP;
    case (c)
      CODE_GND:    a = ADDR_STEP0;
      CODE_STEP1:  a = ADDR_STEP1;
      CODE_STEP2:  a = ADDR_STEP2;
      CODE_STEP3:  a = ADDR_STEP3;
      CODE_STEP4:  a = ADDR_STEP4;
      CODE_STEP5:  a = ADDR_STEP5;
      CODE_STEP6:  a = ADDR_STEP6;
      CODE_STEP7:  a = ADDR_STEP7;
      CODE_STEP8:  a = ADDR_STEP8;
      CODE_STEP9:  a = ADDR_STEP9;
      CODE_STEP10: a = ADDR_STEP10;
      CODE_STEP11: a = ADDR_STEP11;
      CODE_STEP12: a = ADDR_STEP12;
      CODE_STEP13: a = ADDR_STEP13;
      CODE_STEP14: a = ADDR_STEP14;
      CODE_STEP15: a = ADDR_STEP15;
      CODE_TOP:    a = ADDR_TOP;
      default:     a = ADDR_TOP;
    endcase
    return a;
  endfunction : addr_of

  function automatic logic [3:0] ones_less2(input logic [CODE_W-1:0] c);
    logic [4:0] n;
    n = '0;
    for (int i = 0; i < CODE_W; i++) begin
      n = n + {4'h0, c[i]};
    end
    // Mode G is step 8; lettered sub-mode index 0 = A
    return (n >= 5'd2) ? 4'(n - 5'd2) : 4'h0;
  endfunction : ones_less2

  ////////////////////////////////////////////////////////////////////////////
  // Post-reset sampling sequencer

  typedef enum logic [2:0] {
    ST_SETTLE = 3'b001,
    ST_LATCH  = 3'b010,
    ST_RUN    = 3'b100
  } seq_e;

  seq_e              st_q, st_d;
  logic [4:0]        cnt_q, cnt_d;
  strap_cfg_s        cfg_q, cfg_d;
  logic              valid_q, valid_d;
  logic [1:0]        cur_q, cur_d;
  logic [CODE_W-1:0] mcode, acode;
  logic              steady;

  always_comb begin
    mcode  = to_code(ms3_q);
    acode  = to_code(as3_q);
    steady = (ms3_q == ms2_q) && (as3_q == as2_q);
    st_d    = st_q;
    cnt_d   = cnt_q;
    cfg_d   = cfg_q;
    valid_d = valid_q;
    cur_d   = cur_q;
    case (st_q)
      ST_SETTLE: begin
        cnt_d = steady ? cnt_q + 5'd1 : 5'd0;
        if (steady && cnt_q == SETTLE_CNT) begin
          st_d = ST_LATCH;
        end
      end
      ST_LATCH: begin
        cfg_d.mode_code   = mcode;
        cfg_d.addr_code   = acode;
        cfg_d.target_addr = addr_of(acode);
        cfg_d.sub_mode    = 4'h0;
        if (mcode == CODE_GND) begin
          cfg_d.mode = OPMODE_STANDDOWN;
        end else if (mcode == CODE_STEP1) begin
          cfg_d.mode = OPMODE_STANDUP;
        end else begin
          cfg_d.mode     = OPMODE_COMPANION;
          cfg_d.sub_mode = ones_less2(mcode);
        end
        valid_d = 1'b1;
        st_d    = ST_RUN;
      end
      ST_RUN: begin
        // Frozen until the next system reset
        st_d = ST_RUN;
      end
      default: begin
        st_d = ST_SETTLE;
      end
    endcase
    if (st_q == ST_RUN && cfg_q.mode == OPMODE_STANDDOWN) begin
      cur_d = {POWER_CAPABILITY_PIN_1_I, POWER_CAPABILITY_PIN_0_I};
    end
    if (SOFT_RESET_I) begin
      st_d    = ST_SETTLE;
      cnt_d   = '0;
      valid_d = 1'b0;
      cur_d   = '0;
      cfg_d   = '{OPMODE_RESET, 4'h0, ADDR_RESET, CODE_RESET, CODE_RESET};
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      st_q    <= ST_SETTLE;
      cnt_q   <= '0;
      valid_q <= 1'b0;
      cur_q   <= '0;
      cfg_q   <= '{OPMODE_RESET, 4'h0, ADDR_RESET, CODE_RESET, CODE_RESET};
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      valid_q <= valid_d;
      cur_q   <= cur_d;
      cfg_q   <= cfg_d;
    end
  end

  assign CFG_O             = cfg_q;
  assign CFG_VALID_O       = valid_q;
  assign STANDALONE_DOWN_O = valid_q && cfg_q.mode == OPMODE_STANDDOWN
                             && !STANDALONE_DISABLE_I;
  assign STANDALONE_UP_O   = valid_q && cfg_q.mode == OPMODE_STANDUP
                             && !STANDALONE_DISABLE_I;
  assign CURRENT_LEVEL_O   = cur_q;

  ////////////////////////////////////////////////////////////////////////////
  // Back-drive monitors, one per CC pin

  back_drive_lane u_cc1 (
    .MCLK_I     (MCLK_I),
    .RST_B_I    (RST_B_I),
    .over_i     (CC1_OVER_SUPPLY_I),
    .enable_i   (BACK_DRIVE_ENABLE_I),
    .debounce_i (VCONN_FAULT_DEBOUNCE_I),
    .clear_i    (POWER_EVENT_CLEAR_I[0]),
    .flag_o     (POWER_EVENT_FLAGS_O.cc1_back_drive_err),
    .fet_off_o  (CC1_VCONN_OFF_O)
  );

  back_drive_lane u_cc2 (
    .MCLK_I     (MCLK_I),
    .RST_B_I    (RST_B_I),
    .over_i     (CC2_OVER_SUPPLY_I),
    .enable_i   (BACK_DRIVE_ENABLE_I),
    .debounce_i (VCONN_FAULT_DEBOUNCE_I),
    .clear_i    (POWER_EVENT_CLEAR_I[1]),
    .flag_o     (POWER_EVENT_FLAGS_O.cc2_back_drive_err),
    .fet_off_o  (CC2_VCONN_OFF_O)
  );

endmodule : strap_decode_backdrive

// ===== strap_decode_backdrive_chk.sv
`timescale 1ns/10ps
module strap_decode_backdrive_chk
  import strap_pkg::*;
(
  input wire logic              MCLK_I,
  input wire logic              RST_B_I,
  input wire logic              SOFT_RESET_I,
  input wire logic [15:0]       MODE_STRAP_PIN_I,
  input wire logic [15:0]       ADDRESS_STRAP_PIN_I,
  input wire logic              POWER_CAPABILITY_PIN_0_I,
  input wire logic              POWER_CAPABILITY_PIN_1_I,
  input wire logic              STANDALONE_DISABLE_I,
  input wire logic              CC1_OVER_SUPPLY_I,
  input wire logic              CC2_OVER_SUPPLY_I,
  input wire logic              BACK_DRIVE_ENABLE_I,
  input wire logic [7:0]        VCONN_FAULT_DEBOUNCE_I,
  input wire logic [1:0]        POWER_EVENT_CLEAR_I,
  input strap_pkg::strap_cfg_s  CFG_O,
  input wire logic              CFG_VALID_O,
  input wire logic              STANDALONE_DOWN_O,
  input wire logic              STANDALONE_UP_O,
  input wire logic [1:0]        CURRENT_LEVEL_O,
  input strap_pkg::power_flags_s POWER_EVENT_FLAGS_O,
  input wire logic              CC1_VCONN_OFF_O,
  input wire logic              CC2_VCONN_OFF_O
);
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RST_B_I);
  sequence s_cc1_held; (CC1_OVER_SUPPLY_I && !SOFT_RESET_I) [*6]; endsequence
  sequence s_cc2_held; (CC2_OVER_SUPPLY_I && !SOFT_RESET_I) [*6]; endsequence
  sequence s_down_run;
    CFG_O.mode == OPMODE_STANDDOWN && !STANDALONE_DISABLE_I && !SOFT_RESET_I;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  AST_HOLD_DEFAULT:
  assert property (!CFG_VALID_O |-> CFG_O.mode == OPMODE_RESET && CFG_O.target_addr == ADDR_RESET)
    else $error("cfg left its default before sampling");
  AST_VALID_HOLD:
  assert property (CFG_VALID_O && !SOFT_RESET_I |=> CFG_VALID_O) else $error("valid dropped");
  AST_CFG_FROZEN:
  assert property (CFG_VALID_O && !SOFT_RESET_I |=> $stable(CFG_O)) else $error("cfg changed");
  AST_SOFT_RESET:
  assert property (SOFT_RESET_I |=> !CFG_VALID_O && POWER_EVENT_FLAGS_O == 2'b00)
    else $error("soft reset did not restart");
  AST_DOWN_OUT:
  assert property (STANDALONE_DOWN_O == (CFG_O.mode == OPMODE_STANDDOWN && !STANDALONE_DISABLE_I))
    else $error("downstream output wrong");
  AST_UP_OUT:
  assert property (STANDALONE_UP_O == (CFG_O.mode == OPMODE_STANDUP && !STANDALONE_DISABLE_I))
    else $error("upstream output wrong");
  AST_COMPANION:
  assert property (CFG_VALID_O |-> (CFG_O.mode == OPMODE_COMPANION) == (CFG_O.mode_code > 16'h0001))
    else $error("companion mode wrong");
  AST_CC1_FLAG:
  assert property (s_cc1_held |-> POWER_EVENT_FLAGS_O.cc1_back_drive_err) else $error("cc1 flag");
  AST_CC2_FLAG:
  assert property (s_cc2_held |-> POWER_EVENT_FLAGS_O.cc2_back_drive_err) else $error("cc2 flag");
  AST_FLAG_STICKY:
  assert property (POWER_EVENT_FLAGS_O.cc1_back_drive_err && !POWER_EVENT_CLEAR_I[0] &&
    !SOFT_RESET_I |=> POWER_EVENT_FLAGS_O.cc1_back_drive_err) else $error("cc1 flag lost");
  AST_FET_CAUSE:
  assert property ($rose(CC1_VCONN_OFF_O) |-> BACK_DRIVE_ENABLE_I && $past(CC1_OVER_SUPPLY_I, 2))
    else $error("fet off without cause");
  AST_CURRENT:
  assert property (s_down_run |=> CURRENT_LEVEL_O ==
    $past({POWER_CAPABILITY_PIN_1_I, POWER_CAPABILITY_PIN_0_I})) else $error("current level");
endmodule : strap_decode_backdrive_chk

bind strap_decode_backdrive strap_decode_backdrive_chk i_chk (.*);

// ===== strap_cc_model.sv
`timescale 1ns/10ps
module strap_cc_model (
  input  wire logic [4:0] mode_step_i,
  input  wire logic [4:0] addr_step_i,
  input  wire logic       cc1_hi_i,
  input  wire logic       cc2_hi_i,
  output logic [15:0]     mode_pins_o,
  output logic [15:0]     addr_pins_o,
  output logic            cc1_over_o,
  output logic            cc2_over_o
);
  // One comparator output high per resistor step passed
  assign mode_pins_o = 16'((17'h1 << mode_step_i) - 17'h1);
  assign addr_pins_o = 16'((17'h1 << addr_step_i) - 17'h1);
  // Cable end pulls the CC pin above supply
  assign cc1_over_o  = cc1_hi_i;
  assign cc2_over_o  = cc2_hi_i;
endmodule : strap_cc_model

// ===== strap_decode_backdrive_test.sv
`timescale 1ns/10ps
module strap_decode_backdrive_test;
  import strap_pkg::*;
  logic MCLK_I = 1'b0, RST_B_I = 1'b0, SOFT_RESET_I = 1'b0, STANDALONE_DISABLE_I = 1'b0;
  logic POWER_CAPABILITY_PIN_0_I = 1'b0, POWER_CAPABILITY_PIN_1_I = 1'b0;
  logic BACK_DRIVE_ENABLE_I = 1'b0, cc1_hi = 1'b0, cc2_hi = 1'b0;
  logic [7:0] VCONN_FAULT_DEBOUNCE_I = 8'h0A;
  logic [1:0] POWER_EVENT_CLEAR_I = 2'h0;
  logic [4:0] mode_step = 5'h0, addr_step = 5'h0;
  wire logic [15:0] MODE_STRAP_PIN_I, ADDRESS_STRAP_PIN_I;
  wire logic CC1_OVER_SUPPLY_I, CC2_OVER_SUPPLY_I;
  strap_cfg_s CFG_O;
  power_flags_s POWER_EVENT_FLAGS_O;
  logic CFG_VALID_O, STANDALONE_DOWN_O, STANDALONE_UP_O, CC1_VCONN_OFF_O, CC2_VCONN_OFF_O;
  logic [1:0] CURRENT_LEVEL_O;
  logic [6:0] addr_tab [17] = '{7'h5F, 7'h5E, 7'h5D, 7'h5C, 7'h6B, 7'h6A, 7'h69, 7'h68, 7'h77,
    7'h76, 7'h75, 7'h74, 7'h71, 7'h73, 7'h70, 7'h72, 7'h48};
  int fail_count = 0, checks = 0, cyc = 0, n;
  strap_decode_backdrive i_dut (.*);
  strap_cc_model i_model (.mode_step_i(mode_step), .addr_step_i(addr_step), .cc1_hi_i(cc1_hi),
    .cc2_hi_i(cc2_hi), .mode_pins_o(MODE_STRAP_PIN_I), .addr_pins_o(ADDRESS_STRAP_PIN_I),
    .cc1_over_o(CC1_OVER_SUPPLY_I), .cc2_over_o(CC2_OVER_SUPPLY_I));
  always #2 MCLK_I = ~MCLK_I;
  always @(posedge MCLK_I) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task sys_reset(input logic hard, input logic [4:0] ms, input logic [4:0] as);
    @(posedge MCLK_I);
    mode_step <= ms;
    addr_step <= as;
    if (hard) RST_B_I <= 1'b0;
    else SOFT_RESET_I <= 1'b1;
    repeat (hard ? 8 : 1) @(posedge MCLK_I);
    RST_B_I <= 1'b1;
    SOFT_RESET_I <= 1'b0;
    n = 0;
    do begin
      @(posedge MCLK_I);
      #1;
      n++;
    end while (CFG_VALID_O !== 1'b1 && n < 40);
    check({31'h0, n >= 17 && n <= 26}, 32'h1);
  endtask : sys_reset
  task check_cfg(input logic [4:0] ms, input logic [4:0] as);
    opmode_e m;
    m = (ms == 0) ? OPMODE_STANDDOWN : (ms == 1) ? OPMODE_STANDUP : OPMODE_COMPANION;
    check({28'h0, CFG_O.mode}, {28'h0, m});
    if (ms > 1) check({28'h0, CFG_O.sub_mode}, 32'(ms - 2));
    check({16'h0, CFG_O.mode_code}, 32'((33'h1 << ms) - 1));
    check({16'h0, CFG_O.addr_code}, 32'((33'h1 << as) - 1));
    check({25'h0, CFG_O.target_addr}, {25'h0, addr_tab[as]});
    check({30'h0, STANDALONE_DOWN_O, STANDALONE_UP_O}, {30'h0, ms == 0, ms == 1});
  endtask : check_cfg
  task t_decode;
    for (int i = 0; i <= 16; i++) begin
      sys_reset(1'b0, 5'(i), 5'(16 - i));
      check_cfg(5'(i), 5'(16 - i));
    end
    $display("test decode done");
  endtask : t_decode
  task t_freeze;
    sys_reset(1'b1, 5'd0, 5'd4);
    @(posedge MCLK_I);
    mode_step <= 5'd1;
    addr_step <= 5'd9;
    for (int k = 0; k < 4; k++) begin
      @(posedge MCLK_I);
      {POWER_CAPABILITY_PIN_1_I, POWER_CAPABILITY_PIN_0_I} <= 2'(k);
      repeat (2) @(posedge MCLK_I);
      #1;
      check({30'h0, CURRENT_LEVEL_O}, 32'(k));
    end
    repeat (30) @(posedge MCLK_I);
    #1;
    check_cfg(5'd0, 5'd4);
    @(posedge MCLK_I);
    STANDALONE_DISABLE_I <= 1'b1;
    @(posedge MCLK_I);
    #1;
    check({31'h0, STANDALONE_DOWN_O}, 32'h0);
    sys_reset(1'b0, 5'd1, 5'd0);
    check({31'h0, STANDALONE_UP_O}, 32'h0);
    @(posedge MCLK_I);
    STANDALONE_DISABLE_I <= 1'b0;
    @(posedge MCLK_I);
    #1;
    check({31'h0, STANDALONE_UP_O}, 32'h1);
    $display("test freeze done");
  endtask : t_freeze
  task t_backdrive;
    @(posedge MCLK_I);
    cc1_hi <= 1'b1;
    repeat (40) @(posedge MCLK_I);
    POWER_EVENT_CLEAR_I <= 2'b01;
    @(posedge MCLK_I);
    POWER_EVENT_CLEAR_I <= 2'b00;
    cc1_hi <= 1'b0;
    #1;
    check({30'h0, POWER_EVENT_FLAGS_O}, 32'h2);
    check({31'h0, CC1_VCONN_OFF_O}, 32'h0);
    repeat (8) @(posedge MCLK_I);
    POWER_EVENT_CLEAR_I <= 2'b01;
    @(posedge MCLK_I);
    POWER_EVENT_CLEAR_I <= 2'b00;
    @(posedge MCLK_I);
    #1;
    check({30'h0, POWER_EVENT_FLAGS_O}, 32'h0);
    BACK_DRIVE_ENABLE_I <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      @(posedge MCLK_I);
      VCONN_FAULT_DEBOUNCE_I <= p ? 8'h20 : 8'h0A;
      cc1_hi <= 1'(p);
      cc2_hi <= 1'(1 - p);
      n = 0;
      do begin
        @(posedge MCLK_I);
        #1;
        n++;
      end while ({CC1_VCONN_OFF_O, CC2_VCONN_OFF_O} === 2'b00 && n < 60);
      check({31'h0, n >= (p ? 35 : 13) && n <= (p ? 39 : 17)}, 32'h1);
      check({30'h0, CC1_VCONN_OFF_O, CC2_VCONN_OFF_O}, p ? 32'h2 : 32'h1);
      @(posedge MCLK_I);
      cc1_hi <= 1'b0;
      cc2_hi <= 1'b0;
      repeat (8) @(posedge MCLK_I);
      #1;
      check({30'h0, CC1_VCONN_OFF_O, CC2_VCONN_OFF_O}, 32'h0);
    end
    $display("test back-drive done");
  endtask : t_backdrive
  task tally_and_finish;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  initial begin
    sys_reset(1'b1, 5'd0, 5'd0);
    t_decode();
    t_freeze();
    t_backdrive();
    tally_and_finish();
  end
endmodule : strap_decode_backdrive_test
